/* design/byte_bit_defs.svh */
// byte_bit_defs.svh: constants for the byte, bit and mask instruction unit
// assumes a 16-bit word and byte addresses formed as word*2 plus lane
`ifndef BYTE_BIT_DEFS_SVH
`define BYTE_BIT_DEFS_SVH
`define OP_BYTE_LOAD 16'h8BF3
`define OP_BYTE_STORE 16'h8BF4
`define OP_BYTE_MOVE 16'h8BF5
`define OP_BYTE_SCAN 16'h8BF7
`define OP_MASK_SET 16'h8BFB
`define OP_MASK_CLEAR 16'h8BFC
`define OP_MASK_TEST 16'h8BFD
`define OP_BYTE_COMPARE 16'h8BFE
`define ACC_BYTE_LIMIT 16'h0004
`define REG_A_WORD 15'h0000
`define REG_B_WORD 15'h0001
`define WORD_ZERO 16'h0000
`define ONE_16 16'h0001
`define SKIP_NONE 2'h0
`define SKIP_ONE 2'h1
`define SKIP_TWO 2'h2
`endif

/* design/byte_bit_pkg.sv */
// byte_bit_pkg.sv: types shared by the byte, bit and mask instruction unit
// assumes byte_bit_defs.svh is compiled alongside
package byte_bit_pkg;
    typedef logic [15:0] word_t;
    typedef logic [14:0] waddr_t;
endpackage

/* design/byte_bit_string_instr_unit.sv */
// byte_bit_string_instr_unit.sv: executes byte string, byte and mask instructions
// assumes a memory with req/ack word handshake, write-only lane enables and a
// protect check that answers with each write; accumulators live in this block
`include "byte_bit_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module byte_bit_string_instr_unit (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic enable_i,
    input wire logic start_i,
    input wire byte_bit_pkg::word_t opcode_i,
    input wire byte_bit_pkg::word_t pc_i,
    input wire logic irq_pending_i,
    input wire logic acc_load_i,
    input wire byte_bit_pkg::word_t acc_a_i,
    input wire byte_bit_pkg::word_t acc_b_i,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [1:0] mem_lane_o,
    output byte_bit_pkg::waddr_t mem_addr_o,
    output byte_bit_pkg::word_t mem_wdata_o,
    input wire logic mem_ack_i,
    input wire byte_bit_pkg::word_t mem_rdata_i,
    input wire logic mem_violation_i,
    output byte_bit_pkg::word_t acc_a_o,
    output byte_bit_pkg::word_t acc_b_o,
    output byte_bit_pkg::word_t pc_next_o,
    output logic busy_o,
    output logic done_o,
    output logic interrupted_o,
    output logic violation_o,
    output logic illegal_o
);
    import byte_bit_pkg::*;

    // ****************************************
    // types and state
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE, ST_FETCH_W2, ST_FETCH_W3, ST_READ_CNT, ST_READ_MASK, ST_READ_TGT,
        ST_WRITE_TGT, ST_READ_SRC, ST_READ_DST, ST_WRITE_BYTE, ST_SAVE_CNT, ST_FINISH
    } state_e;
    typedef enum logic [2:0] {
        K_LOAD, K_STORE, K_MOVE, K_SCAN, K_SET, K_CLEAR, K_TEST, K_COMPARE
    } kind_e;

    state_e state_reg;
    kind_e kind_reg;
    word_t a_reg, b_reg, a0_reg, b0_reg, cnt_reg, cnt0_reg, w2_reg, w3_reg;
    word_t pc_reg, data_reg, mask_reg, pc_next_reg;
    logic [1:0] skip_reg;
    logic done_reg, intr_reg, viol_reg, ill_reg;

    // ****************************************
    // helpers
    // ****************************************
    // byte at a byte address out of a word, upper lane is even
    function automatic logic [7:0] lane_of(input word_t w, input logic odd);
        lane_of = odd ? w[7:0] : w[15:8];
    endfunction

    // low byte addresses reach the accumulators rather than memory
    function automatic logic is_acc(input word_t badr);
        is_acc = (badr < `ACC_BYTE_LIMIT);
    endfunction

    function automatic logic [7:0] acc_byte(input word_t badr, input word_t a, input word_t b);
        acc_byte = lane_of(badr[1] ? b : a, badr[0]);
    endfunction

    // place byte into one lane of a word, keeping the sibling lane
    function automatic word_t put_lane(input word_t w, input logic odd, input logic [7:0] v);
        put_lane = odd ? {w[15:8], v} : {v, w[7:0]};
    endfunction

    // ****************************************
    // combinational memory request
    // ****************************************
    word_t byte_adr;
    logic acc_hit;
    logic [7:0] cur_byte;
    always_comb begin
        byte_adr = (state_reg == ST_READ_DST || state_reg == ST_WRITE_BYTE) ? b_reg : a_reg;
        if (kind_reg == K_LOAD || kind_reg == K_STORE || kind_reg == K_SCAN) begin
            byte_adr = b_reg;
        end
        acc_hit = is_acc(byte_adr);
        cur_byte = acc_hit ? acc_byte(byte_adr, a_reg, b_reg) :
                   lane_of(mem_rdata_i, byte_adr[0]);
        mem_req_o = 1'b0;
        mem_we_o = 1'b0;
        mem_lane_o = 2'b11;
        mem_addr_o = byte_adr[15:1];
        mem_wdata_o = `WORD_ZERO;
        unique case (state_reg)
            ST_FETCH_W2: begin
                mem_req_o = 1'b1;
                mem_addr_o = 15'(pc_reg + `ONE_16);
            end
            ST_FETCH_W3: begin
                mem_req_o = 1'b1;
                mem_addr_o = 15'(pc_reg + 16'h0002);
            end
            ST_READ_CNT, ST_READ_MASK: begin
                mem_req_o = 1'b1;
                mem_addr_o = w2_reg[14:0];
            end
            ST_READ_TGT: begin
                mem_req_o = 1'b1;
                mem_addr_o = w3_reg[14:0];
            end
            ST_WRITE_TGT: begin
                mem_req_o = 1'b1;
                mem_we_o = 1'b1;
                mem_addr_o = w3_reg[14:0];
                mem_wdata_o = data_reg;
            end
            ST_SAVE_CNT: begin
                mem_req_o = 1'b1;
                mem_we_o = 1'b1;
                mem_addr_o = 15'(pc_reg + 16'h0002);
                mem_wdata_o = cnt_reg;
            end
            ST_READ_SRC, ST_READ_DST: mem_req_o = !acc_hit;
            ST_WRITE_BYTE: begin
                mem_req_o = !acc_hit;
                mem_we_o = 1'b1;
                mem_lane_o = b_reg[0] ? 2'b01 : 2'b10;
                mem_wdata_o = {data_reg[7:0], data_reg[7:0]};
            end
            default: ;
        endcase
    end

    wire logic step = mem_ack_i || (!mem_req_o && state_reg != ST_IDLE);
    wire logic wr_blocked = mem_ack_i && mem_we_o && mem_violation_i;

    // ****************************************
    // sequencer and accumulators
    // ****************************************
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= ST_IDLE;
            kind_reg <= K_LOAD;
            a_reg <= `WORD_ZERO; b_reg <= `WORD_ZERO;
            a0_reg <= `WORD_ZERO; b0_reg <= `WORD_ZERO;
            cnt_reg <= `WORD_ZERO; cnt0_reg <= `WORD_ZERO;
            w2_reg <= `WORD_ZERO; w3_reg <= `WORD_ZERO;
            pc_reg <= `WORD_ZERO; data_reg <= `WORD_ZERO; mask_reg <= `WORD_ZERO;
            pc_next_reg <= `WORD_ZERO; skip_reg <= `SKIP_NONE;
            done_reg <= 1'b0; intr_reg <= 1'b0; viol_reg <= 1'b0; ill_reg <= 1'b0;
        end else if (enable_i) begin
            done_reg <= 1'b0;
            intr_reg <= 1'b0;
            viol_reg <= 1'b0;
            ill_reg <= 1'b0;
            if (acc_load_i && state_reg == ST_IDLE) begin
                a_reg <= acc_a_i;
                b_reg <= acc_b_i;
            end
            unique case (state_reg)
                ST_IDLE: if (start_i) begin
                    pc_reg <= pc_i;
                    a0_reg <= a_reg;
                    b0_reg <= b_reg;
                    skip_reg <= `SKIP_NONE;
                    state_reg <= ST_FETCH_W2;
                    unique case (opcode_i)
                        `OP_BYTE_LOAD: begin kind_reg <= K_LOAD; state_reg <= ST_READ_SRC; end
                        `OP_BYTE_STORE: begin
                            kind_reg <= K_STORE;
                            data_reg <= a_reg;
                            state_reg <= ST_WRITE_BYTE;
                        end
                        `OP_BYTE_SCAN: begin kind_reg <= K_SCAN; state_reg <= ST_READ_SRC; end
                        `OP_BYTE_MOVE: kind_reg <= K_MOVE;
                        `OP_BYTE_COMPARE: kind_reg <= K_COMPARE;
                        `OP_MASK_SET: kind_reg <= K_SET;
                        `OP_MASK_CLEAR: kind_reg <= K_CLEAR;
                        `OP_MASK_TEST: kind_reg <= K_TEST;
                        default: begin
                            ill_reg <= 1'b1;
                            done_reg <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                    endcase
                end
                ST_FETCH_W2: if (step) begin
                    w2_reg <= mem_rdata_i;
                    state_reg <= ST_FETCH_W3;
                end
                ST_FETCH_W3: if (step) begin
                    w3_reg <= mem_rdata_i;
                    state_reg <= (kind_reg == K_MOVE || kind_reg == K_COMPARE) ?
                                 ST_READ_CNT : ST_READ_MASK;
                end
                ST_READ_CNT: if (step) begin
                    // nonzero reserved word means resuming after an interrupt
                    cnt_reg <= (w3_reg != `WORD_ZERO) ? w3_reg : mem_rdata_i;
                    cnt0_reg <= mem_rdata_i;
                    if (w3_reg != `WORD_ZERO) begin
                        // resumed: B already moved past the bytes done before
                        b0_reg <= b_reg - (mem_rdata_i - w3_reg);
                    end
                    state_reg <= ST_READ_SRC;
                end
                ST_READ_MASK: if (step) begin
                    mask_reg <= mem_rdata_i;
                    state_reg <= ST_READ_TGT;
                end
                ST_READ_TGT: if (step) begin
                    unique case (kind_reg)
                        K_SET: begin
                            data_reg <= mem_rdata_i | mask_reg;
                            state_reg <= ST_WRITE_TGT;
                        end
                        K_CLEAR: begin
                            data_reg <= mem_rdata_i & ~mask_reg;
                            state_reg <= ST_WRITE_TGT;
                        end
                        default: begin
                            skip_reg <= ((mem_rdata_i & mask_reg) == mask_reg) ?
                                        `SKIP_NONE : `SKIP_ONE;
                            state_reg <= ST_FINISH;
                        end
                    endcase
                end
                ST_WRITE_TGT: if (step) begin
                    viol_reg <= wr_blocked;
                    state_reg <= ST_FINISH;
                end
                ST_READ_SRC: if (step) begin
                    unique case (kind_reg)
                        K_LOAD: begin
                            a_reg <= {8'h00, cur_byte};
                            b_reg <= b_reg + `ONE_16;
                            state_reg <= ST_FINISH;
                        end
                        K_SCAN: begin
                            if (cur_byte == a_reg[7:0]) begin
                                state_reg <= ST_FINISH;
                            end else if (cur_byte == a_reg[15:8]) begin
                                skip_reg <= `SKIP_ONE;
                                b_reg <= b_reg + `ONE_16;
                                state_reg <= ST_FINISH;
                            end else begin
                                b_reg <= b_reg + `ONE_16;
                                if (irq_pending_i) begin
                                    intr_reg <= 1'b1;
                                    state_reg <= ST_IDLE;
                                end
                            end
                        end
                        default: begin
                            data_reg <= {8'h00, cur_byte};
                            state_reg <= (kind_reg == K_MOVE) ? ST_WRITE_BYTE : ST_READ_DST;
                        end
                    endcase
                end
                ST_READ_DST: if (step) begin
                    // unsigned byte order, string 1 from A, string 2 from B
                    if (data_reg[7:0] != cur_byte) begin
                        skip_reg <= (data_reg[7:0] < cur_byte) ? `SKIP_ONE : `SKIP_TWO;
                        b_reg <= b0_reg + cnt0_reg;
                        state_reg <= ST_FINISH;
                    end else begin
                        a_reg <= a_reg + `ONE_16;
                        b_reg <= b_reg + `ONE_16;
                        cnt_reg <= cnt_reg - `ONE_16;
                        if (cnt_reg == `ONE_16) begin
                            // equal exit: both advanced by the full count
                            state_reg <= ST_FINISH;
                        end else if (irq_pending_i) begin
                            state_reg <= ST_SAVE_CNT;
                        end else begin
                            state_reg <= ST_READ_SRC;
                        end
                    end
                end
                ST_WRITE_BYTE: if (step) begin
                    // an accumulator target overwrites the pointers themselves
                    if (acc_hit) begin
                        if (b_reg[1]) begin
                            b_reg <= put_lane(b_reg, b_reg[0], data_reg[7:0]) + `ONE_16;
                        end else begin
                            a_reg <= put_lane(a_reg, b_reg[0], data_reg[7:0]);
                            b_reg <= b_reg + `ONE_16;
                        end
                    end else begin
                        b_reg <= b_reg + `ONE_16;
                    end
                    if (wr_blocked) begin
                        viol_reg <= 1'b1;
                        state_reg <= ST_FINISH;
                    end else if (kind_reg == K_STORE) begin
                        state_reg <= ST_FINISH;
                    end else begin
                        if (!(acc_hit && !b_reg[1])) begin
                            a_reg <= a_reg + `ONE_16;
                        end
                        cnt_reg <= cnt_reg - `ONE_16;
                        if (cnt_reg == `ONE_16) begin
                            state_reg <= ST_FINISH;
                        end else if (irq_pending_i) begin
                            state_reg <= ST_SAVE_CNT;
                        end else begin
                            state_reg <= ST_READ_SRC;
                        end
                    end
                end
                ST_SAVE_CNT: if (step) begin
                    intr_reg <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                ST_FINISH: begin
                    done_reg <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // program counter on exit
    // ****************************************
    always_comb begin
        unique case (kind_reg)
            K_LOAD, K_STORE, K_SCAN: pc_next_o = pc_reg + `ONE_16 + {14'h0000, skip_reg};
            default: pc_next_o = pc_reg + 16'h0003 + {14'h0000, skip_reg};
        endcase
    end

    assign acc_a_o = a_reg;
    assign acc_b_o = b_reg;
    assign busy_o = (state_reg != ST_IDLE);
    assign done_o = done_reg;
    assign interrupted_o = intr_reg;
    assign violation_o = viol_reg;
    assign illegal_o = ill_reg;

    // ****************************************
    // checks
    // ****************************************
    a_acc_no_mem: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state_reg == ST_READ_SRC && acc_hit) |-> !mem_req_o)
        else $error("accumulator byte went to memory");
    a_mask_set_wr: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state_reg == ST_WRITE_TGT && kind_reg == K_SET) |-> ((mem_wdata_o & mask_reg) == mask_reg))
        else $error("mask set lost a bit");
    a_mask_clr_wr: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state_reg == ST_WRITE_TGT && kind_reg == K_CLEAR) |-> ((mem_wdata_o & mask_reg) == 16'h0000))
        else $error("mask clear left a bit");
    a_store_lane: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state_reg == ST_WRITE_BYTE && mem_req_o) |-> (mem_lane_o != 2'b11))
        else $error("byte write hit both lanes");
    a_load_zero: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (enable_i && state_reg == ST_READ_SRC && kind_reg == K_LOAD && step)
        |=> (a_reg[15:8] == 8'h00 && b_reg == $past(b_reg) + 16'h0001))
        else $error("load byte result wrong");
    a_cmp_b_end: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (done_reg && kind_reg == K_COMPARE) |-> (b_reg == b0_reg + cnt0_reg))
        else $error("compare left B wrong");
    a_save_word3: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (state_reg == ST_SAVE_CNT) |-> (mem_we_o && mem_addr_o == 15'(pc_reg + 16'h0002)))
        else $error("count not saved in word 3");
    a_test_skip: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (done_reg && kind_reg == K_TEST) |-> (skip_reg != `SKIP_TWO))
        else $error("test bits skipped two");
endmodule // byte_bit_string_instr_unit

`default_nettype wire

/* sim/mem_protect_model.sv */
// mem_protect_model.sv: word memory with write protection below a fence
// assumes the unit's req/ack handshake; the bench preloads mem by hierarchy
`timescale 1ns/1ps
`default_nettype none
module mem_protect_model #(parameter int FENCE = 64) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic slow_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [1:0] mem_lane_i,
    input wire byte_bit_pkg::waddr_t mem_addr_i,
    input wire byte_bit_pkg::word_t mem_wdata_i,
    output logic mem_ack_o,
    output byte_bit_pkg::word_t mem_rdata_o,
    output logic mem_violation_o
);
    import byte_bit_pkg::*;
    word_t mem [0:32767];
    int wait_cnt;
    initial for (int k = 0; k < 32768; k++) mem[k] = 16'(k * 40503);
    // released read data flips, so a late sample never sees a stale word
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mem_ack_o <= 1'b0;
            mem_violation_o <= 1'b0;
            mem_rdata_o <= 16'hA5A5;
            wait_cnt = 0;
        end else if (mem_ack_o) begin
            mem_ack_o <= 1'b0;
            mem_violation_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            wait_cnt = slow_i ? $urandom_range(3) : 0;
        end else if (mem_req_i && wait_cnt > 0) begin
            wait_cnt--;
        end else if (mem_req_i) begin
            mem_ack_o <= 1'b1;
            if (!mem_we_i) begin
                mem_rdata_o <= mem[mem_addr_i];
            end else if (mem_addr_i < FENCE) begin
                mem_violation_o <= 1'b1;
            end else begin
                if (mem_lane_i[1]) mem[mem_addr_i][15:8] <= mem_wdata_i[15:8];
                if (mem_lane_i[0]) mem[mem_addr_i][7:0] <= mem_wdata_i[7:0];
            end
        end
    end
endmodule // mem_protect_model
`default_nettype wire

/* sim/byte_bit_string_instr_unit_bench.sv */
// byte_bit_string_instr_unit_bench.sv: random and corner tests of the byte/mask unit
// assumes mem_protect_model as memory, preloaded and read back by hierarchy
`include "byte_bit_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module byte_bit_string_instr_unit_bench;
    import byte_bit_pkg::*;
    localparam word_t P = 16'h0200;
    logic clock_i, reset_n_i, start_i, irq_pending_i, acc_load_i, slow, mem_req, mem_we;
    logic mem_ack, mem_viol, busy, done, intr, viol, ill;
    logic [1:0] mem_lane;
    logic [3:0] got_f;
    waddr_t mem_addr;
    word_t opcode_i, acc_a_i, acc_b_i, mem_wdata, mem_rdata, acc_a, acc_b, pc_nx, got_pc;
    int error_cnt, total_checks;
    byte_bit_string_instr_unit byte_bit_string_instr_unit_inst (.clock_i(clock_i),
        .reset_n_i(reset_n_i), .enable_i(1'b1), .start_i(start_i), .opcode_i(opcode_i),
        .pc_i(P), .irq_pending_i(irq_pending_i), .acc_load_i(acc_load_i), .acc_a_i(acc_a_i),
        .acc_b_i(acc_b_i), .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_lane_o(mem_lane),
        .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_ack_i(mem_ack),
        .mem_rdata_i(mem_rdata), .mem_violation_i(mem_viol), .acc_a_o(acc_a), .acc_b_o(acc_b),
        .pc_next_o(pc_nx), .busy_o(busy), .done_o(done), .interrupted_o(intr),
        .violation_o(viol), .illegal_o(ill));
    mem_protect_model mem_protect_model_inst (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .slow_i(slow), .mem_req_i(mem_req), .mem_we_i(mem_we), .mem_lane_i(mem_lane),
        .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata), .mem_ack_o(mem_ack),
        .mem_rdata_o(mem_rdata), .mem_violation_o(mem_viol));
    // ****************************************
    // helpers
    // ****************************************
    function automatic word_t rm(input word_t a);
        return mem_protect_model_inst.mem[a[14:0]];
    endfunction
    function automatic logic [7:0] rb(input word_t a);
        word_t w;
        w = rm({1'b0, a[15:1]});
        return a[0] ? w[7:0] : w[15:8];
    endfunction
    task automatic wm(input word_t a, input word_t v);
        mem_protect_model_inst.mem[a[14:0]] = v;
    endtask
    task automatic wb(input word_t a, input logic [7:0] v);
        if (a[0]) mem_protect_model_inst.mem[a[15:1]][7:0] = v;
        else mem_protect_model_inst.mem[a[15:1]][15:8] = v;
    endtask
    task automatic cw(input word_t got, input word_t exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cf(input logic got, input logic exp);
        cw({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic setacc(input word_t a, input word_t b);
        @(posedge clock_i);
        acc_load_i <= 1'b1;
        acc_a_i <= a;
        acc_b_i <= b;
        @(posedge clock_i);
        acc_load_i <= 1'b0;
    endtask
    // start is held one edge only; held longer it is ignored while busy but taken again in ST_IDLE, as after an illegal opcode
    task automatic run(input word_t op);
        int n;
        @(posedge clock_i);
        start_i <= 1'b1;
        opcode_i <= op;
        @(posedge clock_i);
        start_i <= 1'b0;
        got_f = 4'h0;
        // violation pulses a cycle ahead of done, so every flag is gathered
        for (n = 0; n < 3000; n++) begin
            #1;
            got_f = got_f | {done, intr, viol, ill};
            if (done === 1'b1 || intr === 1'b1) break;
            @(posedge clock_i);
        end
        if (n == 3000) error_cnt++;
        got_pc = pc_nx;
        cf(busy, 1'b0);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        word_t a, b, m, t, s1, s2, exp;
        int i, j, k, n;
        logic [7:0] v;
        {start_i, irq_pending_i, acc_load_i, slow, reset_n_i} = 5'h00;
        {opcode_i, acc_a_i, acc_b_i} = 48'h0;
        error_cnt = 0;
        total_checks = 0;
        void'($urandom(32'hBFF4));
        repeat (12) @(posedge clock_i);
        reset_n_i <= 1'b1;
        for (i = 0; i < 8; i++) begin
            slow <= i[0];
            a = 16'($urandom);
            b = 16'h2000 + 16'($urandom_range(8191));
            exp = rm({1'b0, b[15:1]});
            exp[(b[0] ? 7 : 15) -: 8] = a[7:0];
            setacc(a, b);
            if (i < 4) begin
                run(`OP_BYTE_LOAD);
                cw(acc_a, {8'h00, rb(b)});
            end else begin
                run(`OP_BYTE_STORE);
                cw(rm({1'b0, b[15:1]}), exp);
            end
            cw(acc_b, b + 16'h0001);
            cw(got_pc, P + 16'h0001);
        end
        setacc(16'hABCD, 16'h0000);
        run(`OP_BYTE_LOAD);
        cw(acc_a, 16'h00AB);
        exp = rm(16'h0020);
        setacc(16'h1234, 16'h0041);
        run(`OP_BYTE_STORE);
        cf(got_f[1], 1'b1);
        cw(rm(16'h0020), exp);
        wm(P + 16'h0001, 16'h0800);
        wm(P + 16'h0002, 16'h0801);
        for (i = 0; i < 4; i++) begin
            m = 16'($urandom);
            t = 16'($urandom) | (i == 3 ? m : 16'h0000);
            wm(16'h0800, m);
            wm(16'h0801, t);
            run(i == 0 ? `OP_MASK_SET : i == 1 ? `OP_MASK_CLEAR : `OP_MASK_TEST);
            exp = i == 0 ? (t | m) : i == 1 ? (t & ~m) : t;
            cw(rm(16'h0801), exp);
            cw(got_pc, P + 16'h0003 + 16'((i == 2 && (t & m) != m) ? 1 : 0));
        end
        wm(P + 16'h0001, 16'h0802);
        for (i = 0; i < 3; i++) begin
            n = $urandom_range(8, 1);
            j = $urandom_range(n - 1);
            s1 = 16'h4001;
            s2 = 16'h5000;
            for (k = 0; k < n; k++) begin
                v = 8'($urandom);
                wb(s1 + 16'(k), v);
                wb(s2 + 16'(k), v);
            end
            // 8'h10 against 8'hF0 only orders right when bytes are unsigned
            if (i > 0) wb(s1 + 16'(j), i == 1 ? 8'h10 : 8'hF0);
            if (i > 0) wb(s2 + 16'(j), i == 1 ? 8'hF0 : 8'h10);
            wm(P + 16'h0002, 16'h0000);
            wm(16'h0802, 16'(n));
            setacc(s1, s2);
            run(`OP_BYTE_COMPARE);
            cw(acc_a, s1 + 16'(i == 0 ? n : j));
            cw(acc_b, s2 + 16'(n));
            cw(got_pc, P + 16'h0003 + 16'(i));
        end
        n = $urandom_range(12, 2);
        s1 = 16'h6001;
        s2 = 16'h7000;
        for (k = 0; k < n; k++) wb(s1 + 16'(k), 8'($urandom));
        wm(P + 16'h0002, 16'h0000);
        wm(16'h0802, 16'(n));
        setacc(s1, s2);
        irq_pending_i <= 1'b1;
        slow <= 1'b1;
        run(`OP_BYTE_MOVE);
        irq_pending_i <= 1'b0;
        cf(got_f[2], 1'b1);
        cf(rm(P + 16'h0002) != 0 && rm(P + 16'h0002) <= n, 1'b1);
        run(`OP_BYTE_MOVE);
        for (k = 0; k < n; k++) begin
            cw({8'h00, rb(s2 + 16'(k))}, {8'h00, rb(s1 + 16'(k))});
        end
        cw(acc_a, s1 + 16'(n));
        cw(acc_b, s2 + 16'(n));
        wm(P + 16'h0002, 16'h0000);
        // a move into the fenced low words must stop with a violation at its first refused byte
        wm(16'h0802, 16'h0002);
        exp = rm(16'h0008);
        setacc(s1, 16'h0010);
        run(`OP_BYTE_MOVE);
        cf(got_f[1], 1'b1);
        cw(rm(16'h0008), exp);
        for (i = 0; i < 3; i++) begin
            a = 16'($urandom);
            a[7:0] = a[15:8] ^ 8'h5A;
            s1 = i == 2 ? 16'hFFFE : 16'h6801;
            n = i == 2 ? 2 : $urandom_range(6, 2);
            for (k = 0; k < n; k++) begin
                v = 8'($urandom);
                while (v == a[15:8] || v == a[7:0]) v++;
                wb(s1 + 16'(k), v);
            end
            if (i < 2) wb(s1 + 16'(n), i == 0 ? a[7:0] : a[15:8]);
            setacc(a, s1);
            run(`OP_BYTE_SCAN);
            cw(acc_b, i == 2 ? 16'h0001 : s1 + 16'(n + i));
            cw(got_pc, P + 16'h0001 + 16'(i > 0 ? 1 : 0));
        end
        run(16'h0000);
        cf(got_f[0], 1'b1);
        test_done();
    end
endmodule // byte_bit_string_instr_unit_bench
`default_nettype wire
